// [cmbx_top.sv]
// Purpose: cpu mailbox and two semaphores on the switch register bus
// Assumes: four requester ports, each holds its request until ack
// Notes: one access is served per cycle, ack and data one cycle later
//
// Operation
// [RULE1] one 32-bit mailbox; set-mask write ors the mask in
// [RULE2] clear-mask write clears masked bits, others keep value
// [RULE3] value register reads mailbox, a write replaces it whole
// [RULE4] every requester port gets identical mailbox behaviour
// [RULE5] two semaphores with separate state and owner
// [RULE6] each bus interface is recorded as its own owner; the code records per port, so pcie and internal cpu both record as port 0
// [RULE7] pcie and internal cpu share one port and one owner code
// [RULE8] take read of a free semaphore returns 1 and records owner
// [RULE9] take read of a held semaphore returns 0, state unchanged
// [RULE10] after taking, all take reads return 0 until release
// [RULE11] writing 1 to the take register releases the semaphore
// [RULE12] release is honoured from any interface, owner or not
// [RULE13] read-only holder register shows owner code or free
// [RULE14] soft interrupt per semaphore, polarity picks free or taken
// [RULE15] semaphore 0 drives first soft line, 1 drives second
// [RULE16] force register asserts each soft line by hand
// [RULE17] each soft line routes to internal cpu or external output
// [RULE18] simultaneous accesses are serialised, none lost

`timescale 1ns/1ps

module cmbx_top
	import cmbx_pkg::*;
(
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic [CMBX_SRC_N-1:0] REQ_I,
	input wire logic [CMBX_SRC_N-1:0] WE_I,
	input wire logic [CMBX_SRC_N*CMBX_ADDR_W-1:0] ADDR_I,
	input wire logic [CMBX_SRC_N*CMBX_DATA_W-1:0] WDATA_I,
	output logic [CMBX_SRC_N-1:0] ACK_O,
	output logic [CMBX_DATA_W-1:0] RDATA_O,
	output logic [CMBX_SEMA_N-1:0] CPU_SOFT_IRQ_O,
	output logic [CMBX_SEMA_N-1:0] EXT_SOFT_IRQ_O
);

	// ****************************************************************
	// arbitration
	// ****************************************************************

	logic [CMBX_SRC_N-1:0] ack_reg;
	logic [CMBX_SRC_N-1:0] ack_next;
	logic [CMBX_SRC_N-1:0] req_live;
	logic acc;
	logic [CMBX_SRC_W-1:0] src;
	logic sel_we;
	logic [CMBX_ADDR_W-1:0] sel_addr;
	logic [CMBX_DATA_W-1:0] sel_wdata;

	// a port whose ack is on the wire still shows its old request
	assign req_live = REQ_I & ~ack_reg;

	// one winner per cycle keeps masked updates and takes atomic
	cmbx_arb u_arb ( // see [RULE18]
		.clk_i(SYS_CLK_I),
		.rstn_i(RSTN_I),
		.req_i(req_live),
		.gnt_valid_o(acc),
		.gnt_idx_o(src)
	);

	// the winner's fields, same path for every port
	assign sel_we = WE_I[src]; // see [RULE4]
	assign sel_addr = ADDR_I[src*CMBX_ADDR_W +: CMBX_ADDR_W];
	assign sel_wdata = WDATA_I[src*CMBX_DATA_W +: CMBX_DATA_W];

	// ****************************************************************
	// decode
	// ****************************************************************

	function automatic logic hit(input logic [CMBX_ADDR_W-1:0] a,
		input logic [CMBX_ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	logic wr_set;
	logic wr_clr;
	logic wr_val;
	logic wr_cfg;
	logic wr_force;
	logic wr_route;
	logic [CMBX_SEMA_N-1:0] take_rd;
	logic [CMBX_SEMA_N-1:0] rel_wr;
	logic [CMBX_SEMA_N-1:0] take_hit;

	assign wr_set = acc && sel_we && hit(sel_addr, CMBX_OFS_MB_SET);
	assign wr_clr = acc && sel_we && hit(sel_addr, CMBX_OFS_MB_CLR);
	assign wr_val = acc && sel_we && hit(sel_addr, CMBX_OFS_MB_VAL);
	assign wr_cfg = acc && sel_we && hit(sel_addr, CMBX_OFS_IRQ_CFG);
	assign wr_force = acc && sel_we && hit(sel_addr, CMBX_OFS_FORCE);
	assign wr_route = acc && sel_we && hit(sel_addr, CMBX_OFS_ROUTE);
	assign take_hit[0] = hit(sel_addr, CMBX_OFS_TAKE0);
	assign take_hit[1] = hit(sel_addr, CMBX_OFS_TAKE1);
	assign take_rd = {CMBX_SEMA_N{acc && !sel_we}} & take_hit;
	// only a written 1 releases; a 0 is ignored
	assign rel_wr = {CMBX_SEMA_N{acc && sel_we && sel_wdata[0]}}
		& take_hit; // see [RULE11] see [RULE12]

	// ****************************************************************
	// mailbox
	// ****************************************************************

	logic [CMBX_DATA_W-1:0] mailbox_reg;
	logic [CMBX_DATA_W-1:0] mailbox_next;

	// set ors the mask in, clear removes it, value replaces
	assign mailbox_next = wr_set ? mailbox_reg | sel_wdata : // see [RULE1]
		wr_clr ? mailbox_reg & ~sel_wdata : // see [RULE2]
		wr_val ? sel_wdata : mailbox_reg; // see [RULE3]

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			mailbox_reg <= CMBX_MB_RST;
		end else begin
			mailbox_reg <= mailbox_next;
		end
	end

	// ****************************************************************
	// semaphores
	// ****************************************************************

	logic [CMBX_SEMA_N-1:0] sema_free;
	logic [CMBX_OWN_W-1:0] sema_owner [CMBX_SEMA_N];

	// port 0 carries both internal cpu and pcie, so they share a code
	generate
		for (genvar n = 0; n < CMBX_SEMA_N; n++) begin : g_sema
			cmbx_sema u_sema ( // see [RULE5] see [RULE6] see [RULE7]
				.clk_i(SYS_CLK_I),
				.rstn_i(RSTN_I),
				.take_i(take_rd[n]),
				.release_i(rel_wr[n]),
				.src_i(src),
				.free_o(sema_free[n]),
				.owner_o(sema_owner[n])
			);
		end
	endgenerate

	// ****************************************************************
	// interrupt configuration
	// ****************************************************************

	logic [CMBX_SEMA_N-1:0] pol_reg;
	logic [CMBX_SEMA_N-1:0] pol_next;
	logic [CMBX_SEMA_N-1:0] force_reg;
	logic [CMBX_SEMA_N-1:0] force_next;
	logic [CMBX_SEMA_N-1:0] route_reg;
	logic [CMBX_SEMA_N-1:0] route_next;

	assign pol_next = wr_cfg ? sel_wdata[1:0] : pol_reg;
	assign force_next = wr_force ? sel_wdata[1:0] : force_reg;
	assign route_next = wr_route ? sel_wdata[1:0] : route_reg;

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pol_reg <= CMBX_POL_RST;
			force_reg <= CMBX_FORCE_RST;
			route_reg <= CMBX_ROUTE_RST;
		end else begin
			pol_reg <= pol_next;
			force_reg <= force_next;
			route_reg <= route_next;
		end
	end

	// ****************************************************************
	// soft interrupts
	// ****************************************************************

	logic [CMBX_SEMA_N-1:0] soft_lvl;
	logic [CMBX_SEMA_N-1:0] cpu_irq_reg;
	logic [CMBX_SEMA_N-1:0] cpu_irq_next;
	logic [CMBX_SEMA_N-1:0] ext_irq_reg;
	logic [CMBX_SEMA_N-1:0] ext_irq_next;

	// polarity 1 fires while taken, 0 while free; bit n is semaphore n
	assign soft_lvl = (pol_reg ^ sema_free) | force_reg; // see [RULE14]
	// see [RULE15] see [RULE16]
	assign cpu_irq_next = soft_lvl & ~route_reg; // see [RULE17]
	assign ext_irq_next = soft_lvl & route_reg;

	// registered so the lines never glitch on decode
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cpu_irq_reg <= '0;
			ext_irq_reg <= '0;
		end else begin
			cpu_irq_reg <= cpu_irq_next;
			ext_irq_reg <= ext_irq_next;
		end
	end

	assign CPU_SOFT_IRQ_O = cpu_irq_reg;
	assign EXT_SOFT_IRQ_O = ext_irq_reg;

	// ****************************************************************
	// read data and acknowledge
	// ****************************************************************

	logic [CMBX_DATA_W-1:0] rd_mux;
	logic [CMBX_DATA_W-1:0] rdata_reg;
	logic [CMBX_DATA_W-1:0] rdata_next;

	// take reads see state before the access; unmapped reads give 0
	always_comb begin
		rd_mux = '0;
		unique case (sel_addr)
			CMBX_OFS_MB_VAL: rd_mux = mailbox_reg;
			CMBX_OFS_IRQ_CFG: rd_mux[1:0] = pol_reg;
			CMBX_OFS_TAKE0: rd_mux[0] = sema_free[0]; // see [RULE8] see [RULE10]
			CMBX_OFS_TAKE1: rd_mux[0] = sema_free[1]; // see [RULE9]
			CMBX_OFS_HOLD0: rd_mux[2:0] = sema_owner[0]; // see [RULE13]
			CMBX_OFS_HOLD1: rd_mux[2:0] = sema_owner[1];
			CMBX_OFS_FORCE: rd_mux[1:0] = force_reg;
			CMBX_OFS_ROUTE: rd_mux[1:0] = route_reg;
			default: rd_mux = '0;
		endcase
	end

	assign rdata_next = (acc && !sel_we) ? rd_mux : '0;
	assign ack_next = acc ? (4'h1 << src) : 4'h0;

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rdata_reg <= '0;
			ack_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
		end
	end

	assign ACK_O = ack_reg;
	assign RDATA_O = rdata_reg;

	// ****************************************************************
	// checks
	// ****************************************************************

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RSTN_I);

	logic take0_held_reg;
	logic take0_held_next;

	// won take on semaphore 0, kept apart from the owner record so a
	// take that the semaphore forgets still trips the retake check
	assign take0_held_next = rel_wr[0] ? 1'b0 :
		(take_rd[0] && sema_free[0]) ? 1'b1 : take0_held_reg;

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			take0_held_reg <= 1'b0;
		end else begin
			take0_held_reg <= take0_held_next;
		end
	end

	sequence s_take0_ok;
		take_rd[0] && sema_free[0];
	endsequence

	sequence s_take0_again;
		take_rd[0] && take0_held_reg;
	endsequence

	property p_mb_set;
		wr_set |=> mailbox_reg == ($past(mailbox_reg) | $past(sel_wdata));
	endproperty
	a_mb_set: assert property (p_mb_set) // see [RULE1]
		else $error("mailbox set lost or touched other bits");

	property p_mb_clr;
		wr_clr |=> mailbox_reg == ($past(mailbox_reg) & ~$past(sel_wdata));
	endproperty
	a_mb_clr: assert property (p_mb_clr) // see [RULE2]
		else $error("mailbox clear wrong");

	property p_mb_val;
		wr_val |=> mailbox_reg == $past(sel_wdata);
	endproperty
	a_mb_val: assert property (p_mb_val) // see [RULE3]
		else $error("mailbox value write not taken whole");

	property p_mb_read;
		acc && !sel_we && sel_addr == CMBX_OFS_MB_VAL
			|=> RDATA_O == $past(mailbox_reg);
	endproperty
	a_mb_read: assert property (p_mb_read) // see [RULE3]
		else $error("mailbox value read wrong");

	property p_take_ok;
		s_take0_ok |=> RDATA_O == 32'h0000_0001
			&& sema_owner[0] == {1'b0, $past(src)} + 3'h1;
	endproperty
	a_take_ok: assert property (p_take_ok) // see [RULE8]
		else $error("free take did not succeed");

	property p_take_busy;
		take_rd[1] && !sema_free[1] |=> RDATA_O == 32'h0000_0000
			&& $stable(sema_owner[1]);
	endproperty
	a_take_busy: assert property (p_take_busy) // see [RULE9]
		else $error("held take changed state");

	property p_take_again;
		s_take0_again |=> RDATA_O == 32'h0000_0000;
	endproperty
	a_take_again: assert property (p_take_again) // see [RULE10]
		else $error("second take returned 1");

	property p_release;
		rel_wr[0] |=> sema_free[0] ##1 sema_free[0] || $past(take_rd[0]);
	endproperty
	a_release: assert property (p_release) // see [RULE11]
		else $error("release did not free semaphore");

	property p_irq_route;
		!route_reg[0] && !$past(wr_route) |-> ##0
			!EXT_SOFT_IRQ_O[0] ##1 CPU_SOFT_IRQ_O[0] == $past(soft_lvl[0]);
	endproperty
	a_irq_route: assert property (p_irq_route) // see [RULE17]
		else $error("soft interrupt on wrong output");

	property p_force;
		force_reg[1] |=> CPU_SOFT_IRQ_O[1] || EXT_SOFT_IRQ_O[1];
	endproperty
	a_force: assert property (p_force) // see [RULE16]
		else $error("forced soft interrupt not seen");

	property p_serial;
		acc |=> $onehot(ACK_O) && ACK_O[$past(src)];
	endproperty
	a_serial: assert property (p_serial) // see [RULE18]
		else $error("access not acknowledged alone");

	property p_hold_read;
		acc && !sel_we && sel_addr == CMBX_OFS_HOLD1
			|=> RDATA_O == {29'h0, $past(sema_owner[1])};
	endproperty
	a_hold_read: assert property (p_hold_read) // see [RULE13]
		else $error("holder read does not show owner");

endmodule

// [cmbx_pkg.sv]
// Purpose: constants shared by the mailbox and semaphore block
// Assumes: word-addressed register bus, one word per register index
// Notes: offsets are register indices on the switch register bus

package cmbx_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int CMBX_SRC_N = 4;
	localparam int CMBX_SRC_W = 2;
	localparam int CMBX_ADDR_W = 4;
	localparam int CMBX_DATA_W = 32;
	localparam int CMBX_OWN_W = 3;
	localparam int CMBX_SEMA_N = 2;

	// ****************************************************************
	// register indices
	// ****************************************************************
	localparam logic [3:0] CMBX_OFS_MB_SET = 4'h0;
	localparam logic [3:0] CMBX_OFS_MB_CLR = 4'h1;
	localparam logic [3:0] CMBX_OFS_MB_VAL = 4'h2;
	localparam logic [3:0] CMBX_OFS_IRQ_CFG = 4'h3;
	localparam logic [3:0] CMBX_OFS_TAKE0 = 4'h4;
	localparam logic [3:0] CMBX_OFS_TAKE1 = 4'h5;
	localparam logic [3:0] CMBX_OFS_HOLD0 = 4'h6;
	localparam logic [3:0] CMBX_OFS_HOLD1 = 4'h7;
	localparam logic [3:0] CMBX_OFS_FORCE = 4'h8;
	localparam logic [3:0] CMBX_OFS_ROUTE = 4'h9;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [31:0] CMBX_MB_RST = 32'h0000_0000;
	localparam logic [1:0] CMBX_POL_RST = 2'h0;
	localparam logic [1:0] CMBX_FORCE_RST = 2'h0;
	localparam logic [1:0] CMBX_ROUTE_RST = 2'h0;
	localparam logic [1:0] CMBX_PTR_RST = 2'h0;

	// ****************************************************************
	// owner encoding: free, or requester index plus one
	// ****************************************************************
	localparam logic [2:0] CMBX_OWN_FREE = 3'h0;

	typedef enum logic [1:0] {
		CMBX_SRC_CORE = 2'b00,
		CMBX_SRC_PAR = 2'b01,
		CMBX_SRC_SER = 2'b10,
		CMBX_SRC_MGMT = 2'b11
	} cmbx_src_t;

endpackage

// [cmbx_arb.sv]
// Purpose: round-robin pick of one register request per cycle
// Assumes: requesters hold their request until acknowledged
// Notes: grant is combinational, pointer moves past each winner

`timescale 1ns/1ps

module cmbx_arb
	import cmbx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [CMBX_SRC_N-1:0] req_i,
	output logic gnt_valid_o,
	output logic [CMBX_SRC_W-1:0] gnt_idx_o
);

	logic [CMBX_SRC_W-1:0] ptr_reg;
	logic [CMBX_SRC_W-1:0] ptr_next;

	// first pending requester at or after the pointer
	function automatic logic [CMBX_SRC_W-1:0] pick(
		input logic [CMBX_SRC_N-1:0] req,
		input logic [CMBX_SRC_W-1:0] ptr);
		logic [CMBX_SRC_W-1:0] idx;
		logic [CMBX_SRC_W-1:0] win;
		logic found;
		win = ptr;
		found = 1'b0;
		for (int k = 0; k < CMBX_SRC_N; k++) begin
			idx = ptr + k[CMBX_SRC_W-1:0];
			if (!found && req[idx]) begin
				win = idx;
				found = 1'b1;
			end
		end
		return win;
	endfunction

	assign gnt_valid_o = |req_i;
	assign gnt_idx_o = pick(req_i, ptr_reg);
	assign ptr_next = gnt_valid_o ? gnt_idx_o + 2'h1 : ptr_reg;

	// fairness pointer
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ptr_reg <= CMBX_PTR_RST;
		end else begin
			ptr_reg <= ptr_next;
		end
	end

endmodule

// [cmbx_sema.sv]
// Purpose: one hardware semaphore with owner record
// Assumes: take and release never arrive in the same cycle
// Notes: owner code is requester index plus one, zero when free

`timescale 1ns/1ps

module cmbx_sema
	import cmbx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic take_i,
	input wire logic release_i,
	input wire logic [CMBX_SRC_W-1:0] src_i,
	output logic free_o,
	output logic [CMBX_OWN_W-1:0] owner_o
);

	logic [CMBX_OWN_W-1:0] owner_reg;
	logic [CMBX_OWN_W-1:0] owner_next;

	// a take on a held semaphore changes nothing
	assign free_o = owner_reg == CMBX_OWN_FREE;
	assign owner_next = release_i ? CMBX_OWN_FREE :
		(take_i && free_o) ? {1'b0, src_i} + 3'h1 : owner_reg;
	assign owner_o = owner_reg;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			owner_reg <= CMBX_OWN_FREE;
		end else begin
			owner_reg <= owner_next;
		end
	end

endmodule

// [cmbx_host.sv]
// Purpose: model of the host cpus on the four register bus ports
// Assumes: one outstanding access per port, driven at falling edges
// Notes: released request lines show inverted values, never stale ones

`timescale 1ns/1ps

module cmbx_host
	import cmbx_pkg::*;
(
	input wire logic clk_i,
	input wire logic [CMBX_SRC_N-1:0] ack_i,
	input wire logic [CMBX_DATA_W-1:0] rdata_i,
	output logic [CMBX_SRC_N-1:0] req_o,
	output logic [CMBX_SRC_N-1:0] we_o,
	output logic [CMBX_SRC_N*CMBX_ADDR_W-1:0] addr_o,
	output logic [CMBX_SRC_N*CMBX_DATA_W-1:0] wdata_o
);
	// ****************************************************************
	// idle state and pacing
	// ****************************************************************
	int idle_n;

	// all lines quiet at time zero
	initial begin
		idle_n = 0;
		req_o = '0;
		we_o = '0;
		addr_o = '0;
		wdata_o = '0;
	end

	// ****************************************************************
	// one access: hold everything until ack is seen, then release
	// ****************************************************************
	// automatic so that several ports may run at once
	task automatic xfer(input int p, input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		repeat (idle_n + 1) @(negedge clk_i);
		req_o[p] = 1'b1;
		we_o[p] = w;
		addr_o[p*CMBX_ADDR_W +: CMBX_ADDR_W] = a;
		wdata_o[p*CMBX_DATA_W +: CMBX_DATA_W] = d;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (ack_i[p] !== 1'b1 && n < 16);
		// a lost ack yields unknown data, so any compare fails
		q = (ack_i[p] === 1'b1) ? rdata_i : 32'hXXXX_XXXX;
		req_o[p] = 1'b0;
		we_o[p] = ~w;
		addr_o[p*CMBX_ADDR_W +: CMBX_ADDR_W] = ~a;
		wdata_o[p*CMBX_DATA_W +: CMBX_DATA_W] = ~d;
	endtask
endmodule

// [tb_cmbx_top.sv]
// Purpose: self-checking bench for the mailbox and semaphore block
// Assumes: host model drives all four ports at falling edges
// Notes: soft interrupt levels are checked two edges after an access or a reset

`timescale 1ns/1ps

module tb_cmbx_top;
	import cmbx_pkg::*;

	logic sys_clk;
	logic rstn;
	logic [3:0] req, we, ack;
	logic [15:0] addr;
	logic [127:0] wdata;
	logic [31:0] rdata, mb, tmp;
	logic [31:0] qa [4];
	logic [1:0] cpu_irq, ext_irq;
	logic [3:0] tk, hd, oh;
	int n_fail, n_checks;

	// ****************************************************************
	// clock, design and host model
	// ****************************************************************
	initial sys_clk = 1'b0;
	always #2 sys_clk = ~sys_clk;

	cmbx_top cmbx_top_i (.SYS_CLK_I(sys_clk), .RSTN_I(rstn), .REQ_I(req),
		.WE_I(we), .ADDR_I(addr), .WDATA_I(wdata), .ACK_O(ack),
		.RDATA_O(rdata), .CPU_SOFT_IRQ_O(cpu_irq),
		.EXT_SOFT_IRQ_O(ext_irq));

	cmbx_host cmbx_host_i (.clk_i(sys_clk), .ack_i(ack), .rdata_i(rdata),
		.req_o(req), .we_o(we), .addr_o(addr), .wdata_o(wdata));

	// ****************************************************************
	// compare and access tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// writes answer with zero data
	task automatic wr(input int p, input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		cmbx_host_i.xfer(p, 1'b1, a, d, q);
		chk("write data", 32'h0000_0000, q);
	endtask

	task automatic rd(input int p, input logic [3:0] a,
		input logic [31:0] e, input string nm);
		logic [31:0] q;
		cmbx_host_i.xfer(p, 1'b0, a, e, q);
		chk(nm, e, q);
	endtask

	// irq levels follow state one edge later; two edges gives margin
	task automatic irq_chk(input logic [1:0] c, input logic [1:0] x);
		repeat (2) @(negedge sys_clk);
		chk("cpu irq", {30'h0, c}, {30'h0, cpu_irq});
		chk("ext irq", {30'h0, x}, {30'h0, ext_irq});
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// watchdog: the tests need about four hundred cycles
	initial begin
		#80000;
		n_fail++;
		summarize();
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		n_fail = 0;
		n_checks = 0;
		rstn = 1'b0;
		repeat (5) @(negedge sys_clk);
		rstn = 1'b1;
		irq_chk(2'b11, 2'b00);
		rd(0, CMBX_OFS_MB_VAL, CMBX_MB_RST, "mailbox reset");
		rd(1, CMBX_OFS_HOLD0, 32'h0000_0000, "holder0 reset");
		rd(2, CMBX_OFS_HOLD1, 32'h0000_0000, "holder1 reset");
		$display("test reset done");

		// every port writes, sets, clears and reads the mailbox
		for (int p = 0; p < 4; p++) begin
			mb = 32'h0F0F_A5A5 + p;
			wr(p, CMBX_OFS_MB_VAL, mb);
			tmp = 32'hF000_0011 >> p;
			wr(p, CMBX_OFS_MB_SET, tmp);
			mb = mb | tmp;
			rd(p, CMBX_OFS_MB_VAL, mb, "mailbox set");
			tmp = 32'h0F00_0005 << p;
			wr((p + 1) % 4, CMBX_OFS_MB_CLR, tmp);
			mb = mb & ~tmp;
			rd(p, CMBX_OFS_MB_VAL, mb, "mailbox clear");
		end
		$display("test mailbox done");

		// take, retake, foreign release, for both semaphores and ports
		for (int s = 0; s < 2; s++) begin
			tk = s ? CMBX_OFS_TAKE1 : CMBX_OFS_TAKE0;
			hd = s ? CMBX_OFS_HOLD1 : CMBX_OFS_HOLD0;
			oh = s ? CMBX_OFS_HOLD0 : CMBX_OFS_HOLD1;
			for (int p = 0; p < 4; p++) begin
				cmbx_host_i.idle_n = p;
				rd(p, tk, 32'h1, "take free");
				rd(p, hd, 32'(p + 1), "holder");
				rd(p, tk, 32'h0, "owner retake");
				rd((p + 1) % 4, tk, 32'h0, "take held");
				rd((p + 2) % 4, hd, 32'(p + 1), "holder kept");
				rd(p, oh, 32'h0000_0000, "other free");
				wr((p + 3) % 4, tk, 32'h0000_0000);
				rd(p, hd, 32'(p + 1), "zero write kept");
				wr((p + 1) % 4, tk, 32'h0000_0001);
				rd(p, hd, 32'h0000_0000, "released");
			end
		end
		cmbx_host_i.idle_n = 0;
		$display("test semaphores done");

		// polarity, force and routing of the soft lines
		rd(0, CMBX_OFS_TAKE0, 32'h1, "take for irq");
		irq_chk(2'b10, 2'b00);
		wr(1, CMBX_OFS_IRQ_CFG, 32'h0000_0003);
		rd(1, CMBX_OFS_IRQ_CFG, 32'h0000_0003, "polarity");
		irq_chk(2'b01, 2'b00);
		wr(2, CMBX_OFS_TAKE0, 32'h0000_0001);
		irq_chk(2'b00, 2'b00);
		wr(3, CMBX_OFS_FORCE, 32'h0000_0002);
		rd(3, CMBX_OFS_FORCE, 32'h0000_0002, "force");
		irq_chk(2'b10, 2'b00);
		wr(0, CMBX_OFS_ROUTE, 32'h0000_0002);
		rd(0, CMBX_OFS_ROUTE, 32'h0000_0002, "route");
		irq_chk(2'b00, 2'b10);
		wr(0, CMBX_OFS_FORCE, 32'h0000_0000);
		wr(0, CMBX_OFS_IRQ_CFG, 32'h0000_0000);
		wr(0, CMBX_OFS_ROUTE, 32'h0000_0001);
		irq_chk(2'b10, 2'b01);
		wr(0, CMBX_OFS_ROUTE, 32'h0000_0000);
		irq_chk(2'b11, 2'b00);
		$display("test interrupts done");

		// all ports race for one semaphore and for the mailbox
		fork
			cmbx_host_i.xfer(0, 1'b0, CMBX_OFS_TAKE1, 32'h0, qa[0]);
			cmbx_host_i.xfer(1, 1'b0, CMBX_OFS_TAKE1, 32'h0, qa[1]);
			cmbx_host_i.xfer(2, 1'b0, CMBX_OFS_TAKE1, 32'h0, qa[2]);
			cmbx_host_i.xfer(3, 1'b0, CMBX_OFS_TAKE1, 32'h0, qa[3]);
		join
		chk("winners", 32'h1, qa[0] + qa[1] + qa[2] + qa[3]);
		wr(0, CMBX_OFS_TAKE1, 32'h0000_0001);
		wr(1, CMBX_OFS_MB_VAL, 32'h8000_0000);
		// the cleared bit is set by no racer, so any order gives one sum
		fork
			wr(0, CMBX_OFS_MB_SET, 32'h0000_0011);
			wr(1, CMBX_OFS_MB_SET, 32'h0000_2200);
			wr(2, CMBX_OFS_MB_SET, 32'h0033_0000);
			wr(3, CMBX_OFS_MB_CLR, 32'h8000_0000);
		join
		rd(2, CMBX_OFS_MB_VAL, 32'h0033_2211, "mailbox race");
		$display("test race done");

		// a reset in mid-run brings mailbox and lines back to idle
		rstn = 1'b0;
		repeat (2) @(negedge sys_clk);
		rstn = 1'b1;
		irq_chk(2'b11, 2'b00);
		rd(3, CMBX_OFS_MB_VAL, CMBX_MB_RST, "mailbox rerun");
		$display("test second reset done");

		// refused and unmapped places
		rd(3, 4'hF, 32'h0000_0000, "unmapped read");
		wr(2, CMBX_OFS_HOLD1, 32'h0000_0007);
		rd(1, CMBX_OFS_HOLD1, 32'h0000_0000, "holder read only");
		$display("test refused done");
		summarize();
	end
endmodule
